// >>> core/pss_sequencer.sv
`timescale 1ns/1ps
module pss_sequencer
   import pss_pkg::*;
#(
   parameter int unsigned MS_CYCLES = TICK_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // register access
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   // commands
   input wire logic turnOnCmd,
   input wire logic turnOffCmd,
   // power stage feedback
   input wire logic [7:0] currentCode,
   input wire logic outputAtZero,
   // power stage control
   output logic switchEn,
   output logic rampUpGo,
   output logic rampDownGo,
   output logic offDone,
   output logic [15:0] targetHalfMv
);

   localparam int DIV_W = $clog2(MS_CYCLES + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);

   logic [7:0] slew_ff;
   logic [7:0] onWait_ff;
   logic [OFF_WAIT_W-1:0] offWait_ff;
   logic [7:0] targetCode_ff;
   logic [7:0] droop_ff;
   logic [7:0] regRdData_ff;
   logic [DIV_W-1:0] divCnt_ff;
   logic [7:0] msLeft_ff;
   pss_state_type state_ff;
   pss_state_type nxt_state;
   logic switchEn_ff;
   logic nxt_switchEn;
   logic rampUpGo_ff;
   logic rampDownGo_ff;
   logic offDone_ff;
   logic [15:0] targetHalfMv_ff;

   // register decode
   wire logic wrSlew = regWrEn && (regAddr == ADDR_SLEW);
   wire logic wrOn = regWrEn && (regAddr == ADDR_ON_WAIT);
   wire logic wrOff = regWrEn && (regAddr == ADDR_OFF_WAIT);
   wire logic wrTarget = regWrEn && (regAddr == ADDR_TARGET);
   wire logic wrDroop = regWrEn && (regAddr == ADDR_DROOP);
   wire logic [7:0] rdMux =
      (regAddr == ADDR_SLEW) ? slew_ff :
      (regAddr == ADDR_ON_WAIT) ? onWait_ff :
      (regAddr == ADDR_OFF_WAIT) ? {2'h0, offWait_ff} : // R8
      (regAddr == ADDR_TARGET) ? targetCode_ff :
      (regAddr == ADDR_DROOP) ? droop_ff : 8'h00;

   // setting registers written by the host
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         slew_ff <= RST_SLEW;
         onWait_ff <= RST_ON_WAIT;
         offWait_ff <= RST_OFF_WAIT;
         targetCode_ff <= RST_TARGET;
         droop_ff <= RST_DROOP;
      end else begin
         if (wrSlew) slew_ff <= regWrData & SLEW_MASK;
         if (wrOn) onWait_ff <= regWrData; // R6
         if (wrOff) offWait_ff <= regWrData[OFF_WAIT_W-1:0]; // R7
         if (wrTarget) targetCode_ff <= regWrData;
         if (wrDroop) droop_ff <= regWrData;
      end
   end

   // read data latched on a read strobe
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) regRdData_ff <= 8'h00;
      else if (regRdEn) regRdData_ff <= rdMux;
   end

   // setpoint decode over three step sizes
   wire logic [15:0] codeWide = {8'h00, targetCode_ff};
   wire logic [15:0] setpointHalf = // R1
      (targetCode_ff <= CODE_FINE_END) ? FINE_BASE + codeWide * FINE_STEP : // R2
      (targetCode_ff <= CODE_MID_END) ? MID_BASE + (codeWide - {8'h00, CODE_FINE_END}) * MID_STEP :
      COARSE_BASE + (codeWide - {8'h00, CODE_MID_END}) * COARSE_STEP;

   // droop: target falls with measured current
   wire logic [DROOP_W-1:0] droopCode = droop_ff[DROOP_LSB +: DROOP_W];
   wire logic [15:0] dropProd = {{(16 - DROOP_W){1'b0}}, droopCode} * {8'h00, currentCode};
   wire logic [15:0] dropHalf = dropProd >> DROOP_SHIFT;
   wire logic [15:0] nxt_targetHalfMv = (dropHalf >= setpointHalf) ? 16'h0000 :
      setpointHalf - dropHalf; // R4

   // remaining wait against ramp-down time, both in half mV
   wire logic slewEn = slew_ff[SLEW_EN_BIT];
   wire logic [13:0] fallRate = pss_fall_rate(slew_ff[FALL_LSB +: FALL_W]);
   wire logic [20:0] rampNeed = {15'h0000, msLeft_ff[OFF_WAIT_W-1:0]} * {7'h00, fallRate};
   wire logic rampFits = {rampNeed, 1'b0} <= {6'h00, setpointHalf}; // R10

   // command acceptance and 1 ms tick
   wire logic acceptOn = turnOnCmd && (state_ff == ST_IDLE);
   wire logic acceptOff = turnOffCmd && ((state_ff == ST_ON) || (state_ff == ST_ON_WAIT));
   wire logic accept = acceptOn || acceptOff;
   wire logic tick = (divCnt_ff == DIV_LAST);
   wire logic waitDone = (msLeft_ff == 8'h00);

   // divider restarted by each accepted command
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) divCnt_ff <= '0;
      else if (accept || tick) divCnt_ff <= '0; // R14
      else divCnt_ff <= divCnt_ff + 1'b1;
   end

   // millisecond wait counter
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) msLeft_ff <= 8'h00;
      else if (acceptOn) msLeft_ff <= onWait_ff; // R5
      else if (acceptOff) msLeft_ff <= {2'h0, offWait_ff}; // R7
      else if (tick && !waitDone) msLeft_ff <= msLeft_ff - 8'h01; // R14
   end

   // sequencer next state
   always_comb begin
      nxt_state = state_ff;
      nxt_switchEn = switchEn_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (acceptOn) nxt_state = ST_ON_WAIT;
         end
         ST_ON_WAIT: begin
            if (acceptOff) nxt_state = ST_OFF_WAIT;
            else if (waitDone) begin // R6
               nxt_state = ST_ON;
               nxt_switchEn = 1'b1;
            end
         end
         ST_ON: begin
            if (acceptOff) nxt_state = ST_OFF_WAIT;
         end
         ST_OFF_WAIT: begin
            if (slewEn && switchEn_ff) begin
               if (rampFits) nxt_state = ST_RAMP_DOWN; // R10
            end else if (waitDone) begin // R12
               nxt_state = ST_IDLE;
               nxt_switchEn = 1'b0;
            end
         end
         ST_RAMP_DOWN: begin
            if (outputAtZero) begin // R9
               nxt_state = ST_IDLE;
               nxt_switchEn = 1'b0;
            end
         end
      endcase
   end

   wire logic upStart = (state_ff == ST_ON_WAIT) && !acceptOff && waitDone;
   wire logic downStart = (state_ff == ST_OFF_WAIT) && (nxt_state == ST_RAMP_DOWN);
   wire logic offEnd = (nxt_state == ST_IDLE) &&
      ((state_ff == ST_OFF_WAIT) || (state_ff == ST_RAMP_DOWN));

   // state and output flops
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ST_IDLE;
         switchEn_ff <= 1'b0;
         rampUpGo_ff <= 1'b0;
         rampDownGo_ff <= 1'b0;
         offDone_ff <= 1'b0;
         targetHalfMv_ff <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
         switchEn_ff <= nxt_switchEn;
         rampUpGo_ff <= upStart;
         rampDownGo_ff <= downStart;
         offDone_ff <= offEnd;
         targetHalfMv_ff <= nxt_targetHalfMv;
      end
   end

   assign regRdData = regRdData_ff;
   assign switchEn = switchEn_ff;
   assign rampUpGo = rampUpGo_ff;
   assign rampDownGo = rampDownGo_ff;
   assign offDone = offDone_ff;
   assign targetHalfMv = targetHalfMv_ff;

   // checks
   a_setpoint_ends: assert property (@(posedge ref_clk) disable iff (!rstn) // R1
      (targetCode_ff == 8'hFF) |-> (setpointHalf == 16'h2AF8))
      else $error("top setpoint code does not give 5.5 V");
   a_subrange_joint: assert property (@(posedge ref_clk) disable iff (!rstn) // R2
      (targetCode_ff == 8'hFB) |-> (setpointHalf == 16'h2968))
      else $error("coarse range does not start at 5.3 V");
   a_droop_lowers: assert property (@(posedge ref_clk) disable iff (!rstn) // R4
      (droopCode != '0 && currentCode >= 8'h04) |=> (targetHalfMv < $past(setpointHalf)))
      else $error("droop did not lower the target");
   a_on_wait_load: assert property (@(posedge ref_clk) disable iff (!rstn) // R5
      (turnOnCmd && state_ff == ST_IDLE) |=>
      (state_ff == ST_ON_WAIT && msLeft_ff == $past(onWait_ff) && divCnt_ff == '0))
      else $error("turn-on command not accepted into the wait");
   a_on_wait_end: assert property (@(posedge ref_clk) disable iff (!rstn) // R6
      (state_ff == ST_ON_WAIT && msLeft_ff == 8'h00 && !turnOffCmd) |=> (rampUpGo && switchEn))
      else $error("ramp up missed at end of turn-on wait");
   a_off_read_zero: assert property (@(posedge ref_clk) disable iff (!rstn) // R8
      (regRdEn && regAddr == ADDR_OFF_WAIT) |=> (regRdData[7:6] == 2'h0))
      else $error("unused turn-off wait bits read nonzero");
   a_slew_ramp_start: assert property (@(posedge ref_clk) disable iff (!rstn) // R10
      (state_ff == ST_OFF_WAIT && slewEn && switchEn && rampFits) |=> rampDownGo ##1 !rampDownGo)
      else $error("ramp down not started when wait matched");
   a_slew_off_end: assert property (@(posedge ref_clk) disable iff (!rstn) // R9
      (state_ff == ST_RAMP_DOWN && outputAtZero) |=> (offDone && !switchEn && state_ff == ST_IDLE))
      else $error("turn-off not ended at zero volts");
   a_hard_off: assert property (@(posedge ref_clk) disable iff (!rstn) // R12
      (state_ff == ST_OFF_WAIT && (!slewEn || !switchEn) && msLeft_ff == 8'h00)
      |=> (offDone && !switchEn))
      else $error("switches not turned off at end of wait");
   a_tick_restart: assert property (@(posedge ref_clk) disable iff (!rstn) // R14
      (turnOffCmd && state_ff == ST_ON) |=> (divCnt_ff == '0) ##1 (divCnt_ff == DIV_W'(1)))
      else $error("tick divider not restarted by command");

endmodule // pss_sequencer

// >>> include/pss_pkg.sv
// Notes on behaviour
// [R1] An 8-bit setpoint code selects one of 256 fixed output voltages from lowest to highest.
// [R2] Codes map on 12.5 mV steps up to 2.000 V, 25 mV steps to 5.25 V, 50 mV steps to 5.5 V.
// [R3] The host groups paralleled converters together before it margins them.
// [R4] A nonzero droop setting lowers the regulated target as measured current rises.
// [R5] The turn-on delay runs from the turn-on command until the upward ramp starts.
// [R6] The turn-on wait is an 8-bit count of 1 ms, 00h giving none and FFh giving 255 ms.
// [R7] The turn-off wait is a 6-bit count of 1 ms in bits 5 to 0, from none up to 63 ms.
// [R8] The upper two bits of the turn-off wait register always read as zero.
// [R9] With falling slew control, the turn-off delay ends when the output reaches zero.
// [R10] With slew control, the ramp down starts once the remaining wait equals voltage over rate.
// [R11] The host picks a turn-off wait long enough that the wait before ramp-down stays positive.
// [R12] Without slew control, both switches turn off when the turn-off wait expires.
// [R13] The host programs waits and slew rates by writing the setting registers.
// [R14] A 1 ms tick comes from the clock, restarted on the cycle a command is accepted.
package pss_pkg;

   // register addresses
   localparam logic [7:0] ADDR_SLEW = 8'h03;
   localparam logic [7:0] ADDR_ON_WAIT = 8'h05;
   localparam logic [7:0] ADDR_OFF_WAIT = 8'h06;
   localparam logic [7:0] ADDR_TARGET = 8'h07;
   localparam logic [7:0] ADDR_DROOP = 8'h08;

   // reset values
   localparam logic [7:0] RST_SLEW = 8'h08;
   localparam logic [7:0] RST_ON_WAIT = 8'h00;
   localparam logic [5:0] RST_OFF_WAIT = 6'h00;
   localparam logic [7:0] RST_TARGET = 8'h00;
   localparam logic [7:0] RST_DROOP = 8'h00;

   // field layouts
   localparam int OFF_WAIT_W = 6;
   localparam int SLEW_EN_BIT = 3;
   localparam int FALL_LSB = 0;
   localparam int FALL_W = 3;
   localparam logic [7:0] SLEW_MASK = 8'h7F;
   localparam int DROOP_LSB = 0;
   localparam int DROOP_W = 3;
   localparam int DROOP_SHIFT = 2;

   // setpoint decode, in units of 0.5 mV
   localparam logic [7:0] CODE_FINE_END = 8'h78;
   localparam logic [7:0] CODE_MID_END = 8'hFA;
   localparam logic [15:0] FINE_BASE = 16'h03E8;
   localparam logic [15:0] MID_BASE = 16'h0FA0;
   localparam logic [15:0] COARSE_BASE = 16'h2904;
   localparam logic [15:0] FINE_STEP = 16'h0019;
   localparam logic [15:0] MID_STEP = 16'h0032;
   localparam logic [15:0] COARSE_STEP = 16'h0064;

   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_PERIOD_US = 1000;
   localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;

   // sequencer states
   typedef enum logic [2:0] {ST_IDLE, ST_ON_WAIT, ST_ON, ST_OFF_WAIT, ST_RAMP_DOWN} pss_state_type;

   // falling slew rate in mV per ms
   function automatic logic [13:0] pss_fall_rate(input logic [2:0] code);
      logic [13:0] rate;
      rate = 14'h0064;
      case (code)
         3'h0: rate = 14'h0064;
         3'h1: rate = 14'h00C8;
         3'h2: rate = 14'h01F4;
         3'h3: rate = 14'h03E8;
         3'h4: rate = 14'h07D0;
         3'h5: rate = 14'h1388;
         default: rate = 14'h206C;
      endcase
      return rate;
   endfunction

endpackage

// >>> verification/pss_stage_model.sv
`timescale 1ns/1ps
module pss_stage_model #(
   parameter int RAMP_CYC = 7
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // ramp control from the sequencer
   input wire logic rampUpGo,
   input wire logic rampDownGo,
   // ramp feedback
   output logic outputAtZero
);
   int cnt;
   // output ramps down over a fixed number of cycles, then reports zero volts
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 0;
         outputAtZero <= 1'b1;
      end else if (rampUpGo) begin
         outputAtZero <= 1'b0;
      end else if (rampDownGo) begin
         cnt <= RAMP_CYC;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else if (cnt == 1) begin
         cnt <= 0;
         outputAtZero <= 1'b1;
      end
   end
endmodule // pss_stage_model

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import pss_pkg::*;
   localparam int MS = 10;
   localparam int RAMP = 7;
   logic ref_clk, rstn, regWrEn, regRdEn, turnOnCmd, turnOffCmd, outputAtZero;
   logic [7:0] regAddr, regWrData, regRdData, currentCode;
   logic switchEn, rampUpGo, rampDownGo, offDone, sawUp, sawDown;
   logic [15:0] targetHalfMv;
   int mismatches, num_checks, downAt, cyc, k;
   logic [7:0] codes [7] = '{8'h00, 8'h01, 8'h78, 8'h79, 8'hFA, 8'hFB, 8'hFF};
   logic [15:0] volts [7] = '{16'h03E8, 16'h0401, 16'h0FA0, 16'h0FD2, 16'h2904, 16'h2968,
      16'h2AF8};

   pss_sequencer #(.MS_CYCLES(MS)) uut (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr),
      .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
      .turnOnCmd(turnOnCmd), .turnOffCmd(turnOffCmd), .currentCode(currentCode),
      .outputAtZero(outputAtZero), .switchEn(switchEn), .rampUpGo(rampUpGo),
      .rampDownGo(rampDownGo), .offDone(offDone), .targetHalfMv(targetHalfMv));
   // lone converter, never margined, so it needs no parallel group
   pss_stage_model #(.RAMP_CYC(RAMP)) stage (.ref_clk(ref_clk), .rstn(rstn),
      .rampUpGo(rampUpGo), .rampDownGo(rampDownGo), .outputAtZero(outputAtZero));

   // free-running clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // host writes one setting register
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge ref_clk);
      regWrEn <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge ref_clk);
      regRdEn <= 1'b0;
      #1 chk({8'h00, regRdData}, {8'h00, exp});
   endtask

   // issue a command and count cycles until its completion pulse
   task automatic run_cmd(input logic on);
      int i;
      sawUp = 1'b0;
      sawDown = 1'b0;
      cyc = 0;
      @(posedge ref_clk);
      if (on) turnOnCmd <= 1'b1;
      else turnOffCmd <= 1'b1;
      for (i = 1; i < 3000 && cyc == 0; i++) begin
         @(posedge ref_clk);
         turnOnCmd <= 1'b0;
         turnOffCmd <= 1'b0;
         #1;
         if (rampUpGo === 1'b1) sawUp = 1'b1;
         if (rampDownGo === 1'b1) begin
            sawDown = 1'b1;
            downAt = i;
         end
         if ((on ? rampUpGo : offDone) === 1'b1) cyc = i;
      end
      if (cyc == 0) begin
         mismatches++;
         tally_and_finish();
      end
   endtask

   task automatic test_regs();
      rd(ADDR_SLEW, 8'h08);
      rd(ADDR_ON_WAIT, 8'h00);
      rd(ADDR_OFF_WAIT, 8'h00);
      wr(ADDR_OFF_WAIT, 8'hFF);
      rd(ADDR_OFF_WAIT, 8'h3F);
      wr(ADDR_ON_WAIT, 8'hFF);
      rd(ADDR_ON_WAIT, 8'hFF);
      wr(8'h2A, 8'h55);
      rd(8'h2A, 8'h00);
      $display("test regs done");
   endtask

   task automatic test_setpoint();
      for (k = 0; k < 7; k++) begin
         wr(ADDR_TARGET, codes[k]);
         repeat (2) @(posedge ref_clk);
         #1 chk(targetHalfMv, volts[k]);
      end
      wr(ADDR_TARGET, 8'h00);
      wr(ADDR_DROOP, 8'h03);
      @(posedge ref_clk);
      currentCode <= 8'h40;
      repeat (3) @(posedge ref_clk);
      #1 chk(targetHalfMv, 16'h03B8);
      wr(ADDR_DROOP, 8'h00);
      $display("test setpoint done");
   endtask

   task automatic test_hard();
      wr(ADDR_SLEW, 8'h00);
      wr(ADDR_ON_WAIT, 8'h03);
      run_cmd(1'b1);
      chk(cyc, 2 + 3 * MS);
      chk(switchEn, 1'b1);
      wr(ADDR_OFF_WAIT, 8'h02);
      run_cmd(1'b0);
      chk(cyc, 2 + 2 * MS);
      chk({sawDown, switchEn}, 2'b00);
      wr(ADDR_ON_WAIT, 8'h00);
      run_cmd(1'b1);
      chk(cyc, 2);
      $display("test hard off done");
   endtask

   task automatic test_slew();
      wr(ADDR_SLEW, 8'h08);
      wr(ADDR_OFF_WAIT, 8'h08);
      run_cmd(1'b0);
      chk(sawDown, 1'b1);
      chk(downAt, 2 + 3 * MS);
      chk(cyc >= downAt + RAMP, 1'b1);
      chk(cyc, downAt + RAMP + 2);
      chk(switchEn, 1'b0);
      // faster falling rate: ramp down starts later in the wait
      wr(ADDR_SLEW, 8'h09);
      run_cmd(1'b1);
      chk(cyc, 2);
      run_cmd(1'b0);
      chk(downAt, 2 + 6 * MS);
      chk(switchEn, 1'b0);
      wr(ADDR_ON_WAIT, 8'h05);
      @(posedge ref_clk);
      turnOnCmd <= 1'b1;
      @(posedge ref_clk);
      turnOnCmd <= 1'b0;
      repeat (10) @(posedge ref_clk);
      run_cmd(1'b0);
      chk({sawUp, sawDown}, 2'b00);
      chk(cyc, 2 + 8 * MS);
      $display("test slew off done");
   endtask

   // main sequence
   initial begin
      mismatches = 0;
      num_checks = 0;
      rstn = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      turnOnCmd = 1'b0;
      turnOffCmd = 1'b0;
      currentCode = 8'h00;
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      #1 chk(targetHalfMv, 16'h03E8);
      test_regs();
      test_setpoint();
      test_hard();
      test_slew();
      tally_and_finish();
   end
endmodule // tb_top
